// *** hdl/asq_pkg.sv ***
// shared constants and types for the converter sequencer
package asq_pkg;
	// -------------------------------------------------
	// register map
	// -------------------------------------------------
	localparam logic [15:0] ADDR_CTL0 = 16'h01A0;
	localparam logic [15:0] ADDR_CTL1 = 16'h01A2;
	localparam logic [15:0] ADDR_FLAG = 16'h01A4;
	localparam logic [15:0] ADDR_IE   = 16'h01A6;
	localparam logic [15:0] ADDR_VEC  = 16'h01A8;
	localparam logic [15:0] ADDR_RES0 = 16'h0140;
	localparam logic [15:0] ADDR_ENT0 = 16'h0080;
	localparam logic [15:0] RST_WORD  = 16'h0000;

	// -------------------------------------------------
	// modes, vectors, timing
	// -------------------------------------------------
	localparam logic [1:0] MODE_SINGLE  = 2'h0;
	localparam logic [1:0] MODE_SEQ     = 2'h1;
	localparam logic [1:0] MODE_RSINGLE = 2'h2;
	localparam logic [1:0] MODE_RSEQ    = 2'h3;
	localparam logic [5:0] VEC_NONE     = 6'h00;
	localparam logic [5:0] VEC_OV       = 6'h02;
	localparam logic [5:0] VEC_TOV      = 6'h04;
	localparam logic [5:0] VEC_FLAG0    = 6'h06;
	localparam logic [3:0] TEMP_CHAN    = 4'hA;
	localparam logic [10:0] CONV_CYCLES = 11'h00D;
	localparam logic [10:0] SHT_CYCLES [0:15] = '{
		11'h004, 11'h008, 11'h010, 11'h020, 11'h040, 11'h060, 11'h080, 11'h0C0,
		11'h100, 11'h180, 11'h200, 11'h300, 11'h400, 11'h400, 11'h400, 11'h400};

	// -------------------------------------------------
	// register layouts
	// -------------------------------------------------
	typedef struct packed {
		logic [3:0] sht_hi;
		logic [3:0] sht_lo;
		logic       multi_sample_convert;
		logic       ref_hi;
		logic       ref_on;
		logic       core_on;
		logic       ovie;
		logic       tovie;
		logic       conversion_enable;
		logic       sc;
	} asq_ctl0_t;

	typedef struct packed {
		logic [3:0] start_idx;
		logic [6:0] rsv_hi;
		logic       trig_ext;
		logic [1:0] mode;
		logic       rsv_lo;
		logic       busy;
	} asq_ctl1_t;

	typedef struct packed {
		logic       last;
		logic [2:0] refsel;
		logic [3:0] chan;
	} asq_entry_t;

	// control toward the analog core
	typedef struct packed {
		logic       sample_control;
		logic       convert_active;
		logic       core_on;
		logic [3:0] channel;
		logic [2:0] refsel;
		logic       ref_power;
		logic       ref_hi;
	} asq_core_t;

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SAMPLE, ST_CONV} asq_fsm_t;
endpackage

// *** hdl/asq_core.sv ***
// converter sequencer: modes, slots, flags, overflow and vector
//
// Operation
// R01: sixteen slots with entries; without last marker in entry 15 wrap to 0
// R02: start index picks the only entry or first entry of a sequence
// R03: hidden pointer steps after each conversion until a marked entry is done
// R04: writing a result sets that slot's flag
// R05: mode 00 single, 01 sequence, 10 repeat single, 11 repeat sequence
// R06: single mode retriggers by start bit; other sources need enable toggled
// R07: sequence-once stops after marked entry; external trigger needs enable toggle
// R08: repeat single converts one channel, overwriting its one slot
// R09: repeat sequence ends pass at marker, restarts from start entry
// R10: multi convert starts on first edge, then auto; later edges ignored
// R11: single mode enable clear aborts at once, result unpredictable
// R12: repeat single stops after conversion; sequences stop after sequence
// R13: mode 0 with enable clear halts immediately in every mode
// R14: sequence without marker ignores enable clear alone
// R15: temperature channel powers reference without touching selections
// R16: eighteen sources; flag requests need its enable and global enable
// R17: result over an unread slot raises overflow
// R18: trigger while converting raises time overflow
// R19: vector reports highest enabled pending source only
// R20: vector 0 none, 2 overflow, 4 time overflow, 6 up for flags
// R21: vector access clears top overflow condition, flags untouched
// R22: slot access clears its flag; software may clear flags directly
// R23: no conversion starts without conversion enable
// R24: sample control fall starts a 13 cycle conversion
// R25: low sample time for entries 0-7, high for 8-15
// R26: flag 15 gives vector 36; lower vector wins
// R27: reset returns pointer, overflows and state machine to idle
`timescale 1ns/100ps
module asq_core (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// register port
	input  wire logic [15:0]       reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [15:0]            reg_rdata,
	// trigger, global enable, analog result
	input  wire logic              sample_trigger_in,
	input  wire logic              global_irq_enable,
	input  wire logic [11:0]       conv_result,
	// analog core control and interrupt
	output asq_pkg::asq_core_t     core_ctl,
	output logic                   irq_req
);
	// -------------------------------------------------
	// state
	// -------------------------------------------------
	typedef struct packed {
		asq_pkg::asq_fsm_t            fsm;
		asq_pkg::asq_ctl0_t           ctl0;
		asq_pkg::asq_ctl1_t           ctl1;
		asq_pkg::asq_entry_t [15:0]   ent;
		logic [15:0][11:0]            res;
		logic [15:0]                  flag;
		logic [15:0]                  ie;
		logic [15:0]                  unread;
		logic                         ov;
		logic                         tov;
		logic [3:0]                   ptr;
		logic [10:0]                  cnt;
		logic                         trig_q;
		logic                         rearm;
		logic [15:0]                  rdata;
		asq_pkg::asq_core_t           core;
		logic                         irq;
	} asq_state_t;

	asq_state_t s_ff;
	asq_state_t nxt_s;

	// -------------------------------------------------
	// decode helpers
	// -------------------------------------------------
	function automatic logic res_hit(input logic [15:0] a);
		res_hit = (a[15:5] == asq_pkg::ADDR_RES0[15:5]) && !a[0];
	endfunction

	function automatic logic ent_hit(input logic [15:0] a);
		ent_hit = (a[15:4] == asq_pkg::ADDR_ENT0[15:4]);
	endfunction

	function automatic logic [10:0] samp_len(input asq_pkg::asq_ctl0_t c,
		input logic [3:0] idx);
		samp_len = idx[3] ? asq_pkg::SHT_CYCLES[c.sht_hi] : asq_pkg::SHT_CYCLES[c.sht_lo]; // R25
	endfunction

	logic        acc;
	logic        trig;
	logic        abort;
	logic        conv_done;
	logic        ov_set;
	logic        tov_set;
	logic        auto_run;
	logic [5:0]  vec;
	logic [3:0]  nptr;
	logic        go;
	logic        last;
	logic        sc_wr;

	// -------------------------------------------------
	// vector priority
	// -------------------------------------------------
	always_comb begin
		vec = asq_pkg::VEC_NONE;
		for (int i = 15; i >= 0; i--) begin
			if (s_ff.flag[i] && s_ff.ie[i])
				vec = 6'(asq_pkg::VEC_FLAG0 + 6'(2 * i)); // R20 R26
		end
		if (s_ff.tov && s_ff.ctl0.tovie)
			vec = asq_pkg::VEC_TOV; // R19
		if (s_ff.ov && s_ff.ctl0.ovie)
			vec = asq_pkg::VEC_OV; // R19
	end

	// -------------------------------------------------
	// next state
	// -------------------------------------------------
	always_comb begin
		nxt_s = s_ff;
		acc = (reg_wr || reg_rd) && (reg_addr == asq_pkg::ADDR_VEC);
		sc_wr = reg_wr && (reg_addr == asq_pkg::ADDR_CTL0) && reg_wdata[0];
		// software start or rising external edge
		trig = s_ff.ctl1.trig_ext ? (sample_trigger_in && !s_ff.trig_q) : sc_wr; // R06
		nxt_s.trig_q = sample_trigger_in;
		abort = (s_ff.ctl1.mode == asq_pkg::MODE_SINGLE) && !s_ff.ctl0.conversion_enable; // R11 R13
		conv_done = (s_ff.fsm == asq_pkg::ST_CONV) && (s_ff.cnt == 11'h001) && !abort;
		auto_run = s_ff.ctl0.multi_sample_convert && (s_ff.ctl1.mode != asq_pkg::MODE_SINGLE);
		// edges during an automatic run are ignored, not overflows
		tov_set = trig && !auto_run && ((s_ff.fsm == asq_pkg::ST_SAMPLE) ||
			(s_ff.fsm == asq_pkg::ST_CONV)); // R18 R10
		ov_set = conv_done && s_ff.unread[s_ff.ptr]; // R17
		last = s_ff.ent[s_ff.ptr].last;
		nptr = s_ff.ptr;
		go = 1'b0;

		// register writes
		if (reg_wr) begin
			if (reg_addr == asq_pkg::ADDR_CTL0) begin
				if (!s_ff.ctl0.conversion_enable)
					nxt_s.ctl0 = reg_wdata;
				else begin
					nxt_s.ctl0.conversion_enable = reg_wdata[1];
					nxt_s.ctl0.sc = reg_wdata[0];
				end
			end
			if (reg_addr == asq_pkg::ADDR_CTL1) begin
				// mode stays writable so a run can be halted
				nxt_s.ctl1.mode = reg_wdata[2:1]; // R13 R14
				if (!s_ff.ctl0.conversion_enable) begin
					nxt_s.ctl1.start_idx = reg_wdata[15:12];
					nxt_s.ctl1.trig_ext = reg_wdata[3];
				end
			end
			if (reg_addr == asq_pkg::ADDR_FLAG)
				nxt_s.flag = reg_wdata; // R22
			if (reg_addr == asq_pkg::ADDR_IE)
				nxt_s.ie = reg_wdata;
			if (ent_hit(reg_addr) && !s_ff.ctl0.conversion_enable)
				nxt_s.ent[reg_addr[3:0]] = reg_wdata[7:0];
			if (res_hit(reg_addr))
				nxt_s.res[reg_addr[4:1]] = reg_wdata[11:0];
		end

		// register reads, data stand one cycle later
		nxt_s.rdata = asq_pkg::RST_WORD;
		if (reg_rd) begin
			if (reg_addr == asq_pkg::ADDR_CTL0)
				nxt_s.rdata = s_ff.ctl0;
			if (reg_addr == asq_pkg::ADDR_CTL1)
				nxt_s.rdata = s_ff.ctl1;
			if (reg_addr == asq_pkg::ADDR_FLAG)
				nxt_s.rdata = s_ff.flag;
			if (reg_addr == asq_pkg::ADDR_IE)
				nxt_s.rdata = s_ff.ie;
			if (reg_addr == asq_pkg::ADDR_VEC)
				nxt_s.rdata = {10'h000, vec};
			if (ent_hit(reg_addr))
				nxt_s.rdata = {8'h00, s_ff.ent[reg_addr[3:0]]};
			if (res_hit(reg_addr))
				nxt_s.rdata = {4'h0, s_ff.res[reg_addr[4:1]]};
		end
		// any slot access frees the slot and drops its flag
		if ((reg_rd || reg_wr) && res_hit(reg_addr)) begin
			nxt_s.flag[reg_addr[4:1]] = 1'b0; // R22
			nxt_s.unread[reg_addr[4:1]] = 1'b0;
		end

		// vector access clears only the overflow it reports
		if (acc && vec == asq_pkg::VEC_OV)
			nxt_s.ov = 1'b0; // R21
		if (acc && vec == asq_pkg::VEC_TOV)
			nxt_s.tov = 1'b0; // R21

		if (!s_ff.ctl0.conversion_enable)
			nxt_s.rearm = 1'b0; // R06 R07

		// -------------------------------------------------
		// sequencer
		// -------------------------------------------------
		case (s_ff.fsm)
			asq_pkg::ST_IDLE, asq_pkg::ST_WAIT: begin
				if (s_ff.fsm == asq_pkg::ST_IDLE)
					nptr = s_ff.ctl1.start_idx; // R02
				if (trig && s_ff.ctl0.conversion_enable && !s_ff.rearm)
					go = 1'b1; // R23
				else if (s_ff.fsm == asq_pkg::ST_WAIT && !s_ff.ctl0.conversion_enable &&
					s_ff.ctl1.mode == asq_pkg::MODE_RSINGLE)
					nxt_s.fsm = asq_pkg::ST_IDLE; // R12
			end
			asq_pkg::ST_SAMPLE: begin
				nxt_s.cnt = 11'(s_ff.cnt - 11'h001);
				if (s_ff.cnt == 11'h001) begin
					nxt_s.fsm = asq_pkg::ST_CONV; // R24
					nxt_s.cnt = asq_pkg::CONV_CYCLES; // R24
				end
			end
			asq_pkg::ST_CONV: begin
				nxt_s.cnt = 11'(s_ff.cnt - 11'h001);
				if (conv_done) begin
					nxt_s.res[s_ff.ptr] = conv_result; // R08
					nxt_s.unread[s_ff.ptr] = 1'b1;
					nxt_s.fsm = asq_pkg::ST_IDLE;
					case (s_ff.ctl1.mode) // R05
						asq_pkg::MODE_SINGLE: begin
							nxt_s.rearm = s_ff.ctl1.trig_ext; // R06
						end
						asq_pkg::MODE_SEQ: begin
							if (last)
								nxt_s.rearm = s_ff.ctl1.trig_ext; // R07
							else begin
								nptr = 4'(s_ff.ptr + 4'h1); // R01 R03
								nxt_s.fsm = asq_pkg::ST_WAIT;
								go = s_ff.ctl0.multi_sample_convert; // R10
							end
						end
						asq_pkg::MODE_RSINGLE: begin
							if (s_ff.ctl0.conversion_enable) begin
								nxt_s.fsm = asq_pkg::ST_WAIT; // R08 R12
								go = s_ff.ctl0.multi_sample_convert; // R10
							end
						end
						default: begin
							// without a marker enable clear never ends the run
							if (last)
								nptr = s_ff.ctl1.start_idx; // R09
							else
								nptr = 4'(s_ff.ptr + 4'h1); // R01 R03 R14
							if (s_ff.ctl0.conversion_enable || !last) begin
								nxt_s.fsm = asq_pkg::ST_WAIT; // R09 R12
								go = s_ff.ctl0.multi_sample_convert; // R10
							end
						end
					endcase
				end
			end
			default: nxt_s.fsm = asq_pkg::ST_IDLE;
		endcase

		nxt_s.ptr = nptr;
		if (go) begin
			nxt_s.fsm = asq_pkg::ST_SAMPLE;
			nxt_s.cnt = samp_len(s_ff.ctl0, nptr); // R25
			nxt_s.ctl0.sc = 1'b0;
		end
		if (abort && s_ff.fsm != asq_pkg::ST_IDLE)
			nxt_s.fsm = asq_pkg::ST_IDLE; // R11 R13
		if (!s_ff.ctl0.conversion_enable && !go)
			nxt_s.ctl0.sc = 1'b0;

		// hardware sets win over clears
		if (conv_done)
			nxt_s.flag[s_ff.ptr] = 1'b1; // R04
		if (ov_set)
			nxt_s.ov = 1'b1; // R17
		if (tov_set)
			nxt_s.tov = 1'b1; // R18

		nxt_s.ctl1.busy = (nxt_s.fsm != asq_pkg::ST_IDLE);
		nxt_s.core.sample_control = (nxt_s.fsm == asq_pkg::ST_SAMPLE);
		nxt_s.core.convert_active = (nxt_s.fsm == asq_pkg::ST_CONV);
		nxt_s.core.core_on = s_ff.ctl0.core_on;
		nxt_s.core.channel = s_ff.ent[nptr].chan;
		nxt_s.core.refsel = s_ff.ent[nptr].refsel; // R15
		nxt_s.core.ref_hi = s_ff.ctl0.ref_hi;
		// temperature sensor needs the reference while in use
		nxt_s.core.ref_power = s_ff.ctl0.ref_on || (s_ff.ent[nptr].chan ==
			asq_pkg::TEMP_CHAN && nxt_s.fsm != asq_pkg::ST_IDLE); // R15
		nxt_s.irq = global_irq_enable && (vec != asq_pkg::VEC_NONE); // R16
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			s_ff <= '0; // R27
		else
			s_ff <= nxt_s;
	end

	assign reg_rdata = s_ff.rdata;
	assign core_ctl  = s_ff.core;
	assign irq_req   = s_ff.irq;

	// -------------------------------------------------
	// checks
	// -------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence seq_done;
		conv_done;
	endsequence

	sequence seq_conv_run;
		$rose(core_ctl.convert_active) ##12 core_ctl.convert_active;
	endsequence

	// an automatic restart straight out of a conversion is not a new start
	chk_no_enc_start: assert property ($rose(core_ctl.sample_control) && // R23
		!$past(core_ctl.convert_active) |-> $past(s_ff.ctl0.conversion_enable))
		else $error("sampling began without enable");
	chk_conv_length: assert property (seq_conv_run |=> !core_ctl.convert_active) // R24
		else $error("conversion not 13 cycles");
	chk_flag_set: assert property (seq_done |=> s_ff.flag[$past(s_ff.ptr)]) // R04
		else $error("result flag not set");
	chk_ov_raise: assert property (seq_done and s_ff.unread[s_ff.ptr] |=> s_ff.ov) // R17
		else $error("overflow missed");
	chk_tov_raise: assert property (tov_set |=> s_ff.tov) // R18
		else $error("time overflow missed");
	chk_ptr_wrap: assert property (seq_done and s_ff.ctl1.mode == asq_pkg::MODE_SEQ &&
		!last && s_ff.ptr == 4'hF |=> s_ff.ptr == 4'h0) // R01
		else $error("pointer did not wrap");
	chk_seq_stop: assert property (seq_done and s_ff.ctl1.mode == asq_pkg::MODE_SEQ &&
		last |=> s_ff.fsm == asq_pkg::ST_IDLE) // R07
		else $error("sequence did not stop");
	chk_rseq_restart: assert property (seq_done and s_ff.ctl1.mode == asq_pkg::MODE_RSEQ && // R09
		last |=> s_ff.ptr == $past(s_ff.ctl1.start_idx))
		else $error("repeat sequence did not restart");
	chk_halt_now: assert property (abort && s_ff.fsm != asq_pkg::ST_IDLE
		|=> s_ff.fsm == asq_pkg::ST_IDLE && !core_ctl.sample_control) // R13
		else $error("halt not immediate");
	chk_vec_ov: assert property (s_ff.ov && s_ff.ctl0.ovie |-> vec == asq_pkg::VEC_OV) // R20
		else $error("overflow vector wrong");
	chk_vec_clear: assert property (acc && vec == asq_pkg::VEC_OV && !conv_done
		|=> !s_ff.ov && s_ff.flag == $past(s_ff.flag)) // R21
		else $error("vector access clear wrong");
	chk_irq_gate: assert property (irq_req |-> $past(global_irq_enable)) // R16
		else $error("request without global enable");
	chk_temp_ref: assert property (core_ctl.convert_active &&
		core_ctl.channel == asq_pkg::TEMP_CHAN |-> core_ctl.ref_power) // R15
		else $error("temperature reference off");
endmodule

// *** dv/asq_analog_model.sv ***
// behavioural analog sample-and-convert core facing the sequencer
`timescale 1ns/100ps
module asq_analog_model (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          reset_n,
	// control from the sequencer, result back
	input  asq_pkg::asq_core_t core_ctl,
	output logic [11:0]        conv_result
);
	logic [7:0] cnt_ff;
	logic       act_ff;

	// -------------------------------------------------
	// result word: channel code and running conversion count
	// -------------------------------------------------
	// count steps when a conversion ends, so each result is unique
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff <= 8'h00;
			act_ff <= 1'b0;
		end else begin
			act_ff <= core_ctl.convert_active;
			if (act_ff && !core_ctl.convert_active) begin
				cnt_ff <= cnt_ff + 8'h01;
			end
		end
	end

	// outside a conversion the word is inverted, so a stale sample shows
	assign conv_result = core_ctl.convert_active ? {core_ctl.channel, cnt_ff}
		: ~{core_ctl.channel, cnt_ff};
endmodule

// *** dv/tb.sv ***
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
module tb;
	logic               clk;
	logic               reset_n;
	logic [15:0]        reg_addr;
	logic [15:0]        reg_wdata;
	logic               reg_wr;
	logic               reg_rd;
	logic [15:0]        reg_rdata;
	logic               sample_trigger_in;
	logic               global_irq_enable;
	logic [11:0]        conv_result;
	asq_pkg::asq_core_t core_ctl;
	logic               irq_req;
	logic               seen_ref = 1'b0;
	int                 n_errors = 0;
	int                 n_compared = 0;
	int                 cyc = 0;
	logic [31:0]        seed;
	logic [7:0]         n_conv;
	logic [31:0]        rv;
	logic [3:0]         idx;
	logic [3:0]         sl [4] = '{4'hF, 4'h0, 4'h1, 4'h2};
	logic [3:0]         ch [4] = '{4'h7, 4'h3, 4'h5, 4'hA};
	localparam logic [15:0] BASE = 16'h001C;

	asq_core asq_core_inst (
		.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sample_trigger_in(sample_trigger_in), .global_irq_enable(global_irq_enable),
		.conv_result(conv_result), .core_ctl(core_ctl), .irq_req(irq_req));

	asq_analog_model asq_analog_model_inst (
		.clk(clk), .reset_n(reset_n), .core_ctl(core_ctl), .conv_result(conv_result));

	// -------------------------------------------------
	// clock, watchdog, monitor
	// -------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (core_ctl.convert_active === 1'b1 && core_ctl.channel === asq_pkg::TEMP_CHAN
			&& core_ctl.ref_power === 1'b1) begin
			seen_ref <= 1'b1;
		end
		if (cyc == 20000) begin
			n_errors++;
			finish_test();
		end
	end

	// -------------------------------------------------
	// helpers
	// -------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic logic [15:0] res_exp(input logic [3:0] c, input logic [7:0] n);
		return {4'h0, c, n};
	endfunction

	function automatic logic [15:0] vec_exp(input logic [3:0] i);
		return {10'h000, asq_pkg::VEC_FLAG0 + {1'b0, i, 1'b0}};
	endfunction

	task automatic finish_test();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic chk_rd(input logic [15:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		chk_word(d, exp);
	endtask

	// polls busy under a bound; sampling plus 13 cycles fits easily
	task automatic wait_idle();
		logic [15:0] d;
		int          i;
		repeat (3) @(posedge clk);
		for (i = 0; i < 200; i++) begin
			rd(asq_pkg::ADDR_CTL1, d);
			if (d[0] === 1'b0) break;
		end
		chk_bit(i < 200, 1'b1);
	endtask

	// setup bits only stick while enable is low; start bit counts once enable is up
	task automatic conv(input logic [15:0] c1, input logic [15:0] c0x = 16'h0000);
		wr(asq_pkg::ADDR_CTL0, BASE);
		wr(asq_pkg::ADDR_CTL1, c1);
		wr(asq_pkg::ADDR_CTL0, BASE | c0x | 16'h0002);
		wr(asq_pkg::ADDR_CTL0, BASE | c0x | 16'h0003);
	endtask

	task automatic pulse();
		@(posedge clk);
		sample_trigger_in <= 1'b1;
		repeat (2) @(posedge clk);
		sample_trigger_in <= 1'b0;
		repeat (40) @(posedge clk);
	endtask

	// -------------------------------------------------
	// main sequence
	// -------------------------------------------------
	initial begin
		reset_n = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		sample_trigger_in = 1'b0;
		global_irq_enable = 1'b1;
		seed = 32'hECA8;
		n_conv = 8'h00;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		chk_rd(asq_pkg::ADDR_CTL0, asq_pkg::RST_WORD);
		chk_rd(asq_pkg::ADDR_CTL1, asq_pkg::RST_WORD);
		chk_rd(asq_pkg::ADDR_VEC, asq_pkg::RST_WORD);
		chk_rd(16'h0300, 16'h0000);
		wr(asq_pkg::ADDR_ENT0, 16'h0003);
		wr(asq_pkg::ADDR_ENT0 + 16'h0001, 16'h0005);
		wr(asq_pkg::ADDR_ENT0 + 16'h0002, 16'h008A);
		wr(asq_pkg::ADDR_ENT0 + 16'h000F, 16'h0007);
		wr(asq_pkg::ADDR_IE, 16'hFFFF);
		// single conversion from entry 1
		conv(16'h1000);
		wait_idle();
		n_conv++;
		chk_rd(asq_pkg::ADDR_FLAG, 16'h0002);
		chk_rd(asq_pkg::ADDR_VEC, vec_exp(4'h1));
		chk_bit(irq_req, 1'b1);
		global_irq_enable <= 1'b0;
		repeat (3) @(posedge clk);
		chk_bit(irq_req, 1'b0);
		global_irq_enable <= 1'b1;
		chk_rd(asq_pkg::ADDR_RES0 + 16'h0002, res_exp(4'h5, n_conv - 8'h01));
		chk_rd(asq_pkg::ADDR_FLAG, 16'h0000);
		// overwrite an unread slot
		conv(16'h1000);
		wait_idle();
		conv(16'h1000);
		wait_idle();
		n_conv += 8'h02;
		chk_rd(asq_pkg::ADDR_VEC, {10'h000, asq_pkg::VEC_OV});
		chk_rd(asq_pkg::ADDR_VEC, vec_exp(4'h1));
		chk_rd(asq_pkg::ADDR_FLAG, 16'h0002);
		chk_rd(asq_pkg::ADDR_RES0 + 16'h0002, res_exp(4'h5, n_conv - 8'h01));
		// sequence once from entry 15, wrapping to the marked entry 2
		conv(16'hF002, 16'h0080);
		wait_idle();
		n_conv += 8'h04;
		chk_rd(asq_pkg::ADDR_FLAG, 16'h8007);
		chk_rd(asq_pkg::ADDR_VEC, vec_exp(4'h0));
		chk_bit(seen_ref, 1'b1);
		for (int i = 0; i < 4; i++) begin
			chk_rd(asq_pkg::ADDR_RES0 + {11'h000, sl[i], 1'b0},
				res_exp(ch[i], n_conv - 8'h04 + 8'(i)));
		end
		chk_rd(asq_pkg::ADDR_VEC, {10'h000, asq_pkg::VEC_NONE});
		// start again while still sampling
		conv(16'h0000);
		wr(asq_pkg::ADDR_CTL0, BASE | 16'h0003);
		wait_idle();
		n_conv++;
		chk_rd(asq_pkg::ADDR_VEC, {10'h000, asq_pkg::VEC_TOV});
		chk_rd(asq_pkg::ADDR_VEC, vec_exp(4'h0));
		chk_rd(asq_pkg::ADDR_RES0, res_exp(4'h3, n_conv - 8'h01));
		// abort in single mode drops the result
		conv(16'h0000);
		wr(asq_pkg::ADDR_CTL0, BASE);
		repeat (40) @(posedge clk);
		chk_rd(asq_pkg::ADDR_FLAG, 16'h0000);
		chk_rd(asq_pkg::ADDR_CTL1, 16'h0000);
		// external trigger: refused without enable, then once per toggle
		wr(asq_pkg::ADDR_CTL1, 16'h0008);
		pulse();
		chk_rd(asq_pkg::ADDR_FLAG, 16'h0000);
		wr(asq_pkg::ADDR_CTL0, BASE | 16'h0002);
		pulse();
		n_conv++;
		chk_rd(asq_pkg::ADDR_RES0, res_exp(4'h3, n_conv - 8'h01));
		pulse();
		chk_rd(asq_pkg::ADDR_FLAG, 16'h0000);
		wr(asq_pkg::ADDR_CTL0, BASE);
		wr(asq_pkg::ADDR_CTL0, BASE | 16'h0002);
		pulse();
		n_conv++;
		chk_rd(asq_pkg::ADDR_RES0, res_exp(4'h3, n_conv - 8'h01));
		// random single conversions, entry 15 first
		for (int k = 0; k < 5; k++) begin
			seed = xs(seed);
			rv = seed;
			idx = (k == 0) ? 4'hF : rv[3:0];
			wr(asq_pkg::ADDR_CTL0, BASE);
			wr(asq_pkg::ADDR_ENT0 + {12'h000, idx}, {12'h000, rv[7:4]});
			conv({idx, 12'h000});
			wait_idle();
			n_conv++;
			chk_rd(asq_pkg::ADDR_VEC, vec_exp(idx));
			chk_rd(asq_pkg::ADDR_RES0 + {11'h000, idx, 1'b0},
				res_exp(rv[7:4], n_conv - 8'h01));
		end
		// repeat single keeps overwriting slot 1, stops after enable clear
		conv(16'h1004, 16'h0080);
		repeat (70) @(posedge clk);
		wr(asq_pkg::ADDR_CTL0, BASE);
		wait_idle();
		chk_rd(asq_pkg::ADDR_VEC, {10'h000, asq_pkg::VEC_OV});
		chk_rd(asq_pkg::ADDR_FLAG, 16'h0002);
		// repeat sequence over entries 3 and 4, several passes, stop at marker
		wr(asq_pkg::ADDR_ENT0 + 16'h0003, 16'h0003);
		wr(asq_pkg::ADDR_ENT0 + 16'h0004, 16'h0085);
		conv(16'h3006, 16'h0080);
		repeat (80) @(posedge clk);
		wr(asq_pkg::ADDR_CTL0, BASE);
		wait_idle();
		chk_rd(asq_pkg::ADDR_VEC, {10'h000, asq_pkg::VEC_OV});
		chk_rd(asq_pkg::ADDR_FLAG, 16'h001A);
		finish_test();
	end
endmodule
